// file: logic/param_command_slave.sv
// command handler for parameter read and write requests.
// assumes a framer below that strips slave address and checksum, flags
// bad frames and broadcasts, and a parameter store that checks values.
`timescale 1ns/1ns
module param_command_slave (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        rx_valid,
	input  wire logic [7:0]  rx_data,
	input  wire logic        rx_end,
	input  wire logic        rx_bad,
	input  wire logic        rx_bcast,
	output logic             tx_valid,
	output logic [7:0]       tx_data,
	output logic             tx_last,
	input  wire logic        tx_ready,
	output logic             param_valid,
	output logic [15:0]      param_addr,
	output logic [15:0]      param_wdata,
	output logic             param_write,
	output logic             param_commit,
	output logic             param_persist,
	input  wire logic        param_ack,
	input  wire logic [15:0] param_rdata,
	input  wire logic [7:0]  param_status,
	input  wire logic        nonvolatile_save_select,
	input  wire logic        nv_save_busy,
	output logic             busy
);
	typedef enum logic [2:0] {st_idle, st_check, st_commit, st_read,
		st_reply} state_t;

	pdu_if p ();

	pdu_collector u_collector (
		.clk      (clk),
		.rst      (rst),
		.rx_valid (rx_valid),
		.rx_data  (rx_data),
		.rx_end   (rx_end),
		.rx_bad   (rx_bad),
		.rx_bcast (rx_bcast),
		.p        (p.collector)
	);

	state_t         state, next_state;
	logic [7:0]     cmd, next_cmd, exc, next_exc, tx_byte, next_tx_byte;
	logic [15:0]    base, next_base, echo, next_echo;
	logic [15:0]    paddr, next_paddr, pwdata, next_pwdata;
	logic [3:0]     n, next_n, wi, next_wi;
	logic [4:0]     idx, next_idx, rlen, next_rlen, off;
	logic           is_exc, next_is_exc, quiet, next_quiet;
	logic           single, multi, wr, supported, cnt_ok, addr_ok;
	logic           last_reg;
	logic [7:0]     verdict;
	logic [16:0]    span;
	pmc_pkg::word_t rd [pmc_pkg::MAX_REGS];
	pmc_pkg::word_t next_rd [pmc_pkg::MAX_REGS];

	assign single = (p.cmd == pmc_pkg::CMD_WRITE1)
		|| (p.cmd == pmc_pkg::CMD_WRITE1_NV);
	assign multi = (p.cmd == pmc_pkg::CMD_WRITEN)
		|| (p.cmd == pmc_pkg::CMD_WRITEN_NV);
	assign wr = single || multi;
	assign supported = wr || (p.cmd == pmc_pkg::CMD_READ);
	// a single write's count field is its value, so no count check
	assign cnt_ok = single || ((p.count != 16'h0000)
		&& (p.count <= pmc_pkg::MAX_COUNT));
	assign span = {1'b0, p.addr} + {1'b0, p.count} - 17'h00001;
	assign addr_ok = single || !span[16];

	// checks in fixed order, all before any parameter is touched
	always_comb begin
		if (p.crc_bad)
			verdict = pmc_pkg::EXC_FRAME;
		else if (!supported)
			verdict = pmc_pkg::EXC_CMD;
		else if (!p.len_ok)
			verdict = pmc_pkg::EXC_FRAME;
		else if (!cnt_ok)
			verdict = pmc_pkg::EXC_COUNT;
		else if (wr && nv_save_busy)
			verdict = pmc_pkg::EXC_BUSY;
		else if (!addr_ok)
			verdict = pmc_pkg::EXC_ADDR;
		else
			verdict = pmc_pkg::EXC_NONE;
	end

	assign last_reg = (wi == n - 4'h1);
	assign param_valid = (state == st_check) || (state == st_commit)
		|| (state == st_read);
	assign param_write = (state == st_check) || (state == st_commit);
	assign param_commit = (state == st_commit);
	// nv commands always persist, plain writes follow the selection
	assign param_persist = (cmd == pmc_pkg::CMD_WRITE1_NV)
		|| (cmd == pmc_pkg::CMD_WRITEN_NV)
		|| nonvolatile_save_select;
	assign param_addr = paddr;
	assign param_wdata = pwdata;
	assign tx_valid = (state == st_reply);
	assign tx_last = tx_valid && (idx == rlen - 5'h01);
	assign tx_data = tx_byte;
	assign busy = (state != st_idle);

	always_comb begin
		next_state = state;
		next_cmd = cmd;
		next_exc = exc;
		next_base = base;
		next_echo = echo;
		next_paddr = paddr;
		next_pwdata = pwdata;
		next_n = n;
		next_wi = wi;
		next_idx = idx;
		next_rlen = rlen;
		next_is_exc = is_exc;
		next_quiet = quiet;
		next_rd = rd;
		unique case (state)
			st_idle: begin
				if (p.done) begin
					next_cmd = p.cmd;
					next_base = p.addr;
					next_paddr = p.addr;
					next_echo = p.count;
					next_n = single ? 4'h1 : p.count[3:0];
					next_pwdata = single ? p.count : p.words[0];
					next_wi = 4'h0;
					next_quiet = p.bcast;
					next_is_exc = (verdict != pmc_pkg::EXC_NONE);
					next_exc = verdict;
					next_idx = 5'h00;
					next_rlen = pmc_pkg::EXC_LEN;
					if (p.bcast && (next_is_exc || !wr))
						next_state = st_idle;
					else if (next_is_exc)
						next_state = st_reply;
					else if (wr)
						next_state = st_check;
					else
						next_state = st_read;
				end
			end
			st_check, st_commit, st_read: begin
				if (param_ack) begin
					if (state == st_read)
						next_rd[wi] = param_rdata;
					// store codes carry 0x02..0x06, 0x16, 0x17, 0x20..0x22
					if (param_status != pmc_pkg::EXC_NONE) begin
						next_is_exc = 1'b1;
						next_exc = (state == st_commit) ? pmc_pkg::EXC_FAIL
							: param_status;
						next_state = quiet ? st_idle : st_reply;
					end else if (!last_reg) begin
						next_wi = wi + 4'h1;
						next_paddr = paddr + 16'h0001;
						next_pwdata = p.words[wi + 4'h1];
					end else if (state == st_check) begin
						// second pass applies what the first one vetted
						next_state = st_commit;
						next_wi = 4'h0;
						next_paddr = base;
						next_pwdata = (n == 4'h1) ? pwdata : p.words[0];
					end else begin
						next_state = quiet ? st_idle : st_reply;
						next_rlen = (state == st_read)
							? pmc_pkg::READ_HDR_LEN + {n, 1'b0}
							: pmc_pkg::ECHO_LEN;
					end
				end
			end
			st_reply: begin
				if (tx_ready) begin
					next_idx = idx + 5'h01;
					if (tx_last) begin
						next_state = st_idle;
						next_idx = 5'h00;
					end
				end
			end
		endcase
		// reply byte for the coming index, high byte first
		off = next_idx - pmc_pkg::READ_HDR_LEN;
		if (next_idx == 5'h00)
			next_tx_byte = next_is_exc ? next_cmd + pmc_pkg::EXC_FLAG
				: next_cmd;
		else if (next_is_exc)
			next_tx_byte = next_exc;
		else if (next_cmd == pmc_pkg::CMD_READ)
			next_tx_byte = (next_idx == 5'h01) ? {3'b000, next_n, 1'b0}
				: (off[0] ? next_rd[off[4:1]][7:0]
				: next_rd[off[4:1]][15:8]);
		else if (next_idx == 5'h01)
			next_tx_byte = next_base[15:8];
		else if (next_idx == 5'h02)
			next_tx_byte = next_base[7:0];
		else if (next_idx == 5'h03)
			next_tx_byte = next_echo[15:8];
		else
			next_tx_byte = next_echo[7:0];
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			state <= st_idle;
			cmd <= 8'h00;
			exc <= 8'h00;
			tx_byte <= 8'h00;
			base <= 16'h0000;
			echo <= 16'h0000;
			paddr <= 16'h0000;
			pwdata <= 16'h0000;
			n <= 4'h0;
			wi <= 4'h0;
			idx <= 5'h00;
			rlen <= 5'h00;
			is_exc <= 1'b0;
			quiet <= 1'b0;
			rd <= '{default: 16'h0000};
		end else begin
			state <= next_state;
			cmd <= next_cmd;
			exc <= next_exc;
			tx_byte <= next_tx_byte;
			base <= next_base;
			echo <= next_echo;
			paddr <= next_paddr;
			pwdata <= next_pwdata;
			n <= next_n;
			wi <= next_wi;
			idx <= next_idx;
			rlen <= next_rlen;
			is_exc <= next_is_exc;
			quiet <= next_quiet;
			rd <= next_rd;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	sequence s_new_req;
		state == st_idle && p.done && !p.bcast;
	endsequence
	sequence s_exc_head;
		state == st_reply && is_exc && idx == 5'h00;
	endsequence

	property p_exc_head;
		s_exc_head |-> tx_data == cmd + 8'h80 && rlen == 5'h02;
	endproperty
	a_exc_head: assert property (p_exc_head) else $error("bad head");
	property p_unsup;
		s_new_req ##0 (!p.crc_bad && !supported) |=>
			state == st_reply && exc == 8'h01;
	endproperty
	a_unsup: assert property (p_unsup) else $error("no 0x01");
	property p_frame;
		s_new_req ##0 p.crc_bad |=> is_exc && exc == 8'h18;
	endproperty
	a_frame: assert property (p_frame) else $error("no 0x18");
	property p_count;
		s_new_req ##0 (!p.crc_bad && supported && p.len_ok && !cnt_ok)
			|=> exc == 8'h17;
	endproperty
	a_count: assert property (p_count) else $error("no 0x17");
	property p_busy;
		s_new_req ##0 (wr && nv_save_busy && !p.crc_bad && p.len_ok
			&& cnt_ok) |=> state == st_reply && exc == 8'h06;
	endproperty
	a_busy: assert property (p_busy) else $error("busy lost");
	property p_bcast;
		state == st_idle && p.done && p.bcast |=> state != st_reply [*2];
	endproperty
	a_bcast: assert property (p_bcast) else $error("bcast reply");
	property p_commit_order;
		$rose(state == st_commit) |-> $past(state) == st_check;
	endproperty
	a_commit_order: assert property (p_commit_order)
		else $error("commit unchecked");
	property p_persist;
		param_commit && (cmd == 8'h41 || cmd == 8'h43) |-> param_persist;
	endproperty
	a_persist: assert property (p_persist) else $error("nv lost");
	property p_plain;
		param_commit && (cmd == 8'h06 || cmd == 8'h10)
			|-> param_persist == nonvolatile_save_select;
	endproperty
	a_plain: assert property (p_plain) else $error("bad persist");
	property p_read_cnt;
		tx_valid && !is_exc && cmd == 8'h03 && idx == 5'h01
			|-> tx_data == {3'b000, n, 1'b0} && rlen == {n, 1'b0} + 5'h02;
	endproperty
	a_read_cnt: assert property (p_read_cnt) else $error("bad count");
	property p_echo;
		tx_valid && !is_exc && cmd != 8'h03 && idx == 5'h01
			|-> tx_data == base[15:8] && rlen == 5'h05;
	endproperty
	a_echo: assert property (p_echo) else $error("bad echo");
	property p_fail;
		param_commit && param_ack && param_status != 8'h00
			|=> is_exc && exc == 8'h04;
	endproperty
	a_fail: assert property (p_fail) else $error("no 0x04");
endmodule // param_command_slave

// file: logic/pdu_collector.sv
// gathers request bytes into command, address, count and data words.
// assumes rx_end comes at least one cycle after the frame's last byte.
`timescale 1ns/1ns
module pdu_collector (
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic       rx_valid,
	input  wire logic [7:0] rx_data,
	input  wire logic       rx_end,
	input  wire logic       rx_bad,
	input  wire logic       rx_bcast,
	pdu_if.collector        p
);
	logic [7:0]     pos, next_pos, nbytes, next_nbytes, cmd, next_cmd;
	logic [7:0]     off;
	logic [15:0]    addr, next_addr, count, next_count;
	logic           done, next_done, len_ok, next_len_ok;
	logic           crc_bad, next_crc_bad, bcast, next_bcast;
	logic           multi;
	pmc_pkg::word_t words [pmc_pkg::MAX_REGS];
	pmc_pkg::word_t next_words [pmc_pkg::MAX_REGS];

	always_comb begin
		next_pos = pos;
		next_nbytes = nbytes;
		next_cmd = cmd;
		next_addr = addr;
		next_count = count;
		next_words = words;
		next_done = 1'b0;
		next_len_ok = len_ok;
		next_crc_bad = crc_bad;
		next_bcast = bcast;
		off = pos - pmc_pkg::POS_DATA;
		multi = (cmd == pmc_pkg::CMD_WRITEN) || (cmd == pmc_pkg::CMD_WRITEN_NV);
		if (rx_valid) begin
			if (pos != 8'hff)
				next_pos = pos + 8'h01;
			// address and values arrive high byte first
			if (pos == pmc_pkg::POS_CMD)
				next_cmd = rx_data;
			else if (pos == pmc_pkg::POS_ADDR_HI)
				next_addr[15:8] = rx_data;
			else if (pos == pmc_pkg::POS_ADDR_LO)
				next_addr[7:0] = rx_data;
			else if (pos == pmc_pkg::POS_CNT_HI)
				next_count[15:8] = rx_data;
			else if (pos == pmc_pkg::POS_CNT_LO)
				next_count[7:0] = rx_data;
			else if (pos == pmc_pkg::POS_NBYTES)
				next_nbytes = rx_data;
			else if (off < pmc_pkg::DATA_BYTES) begin
				if (off[0])
					next_words[off[4:1]][7:0] = rx_data;
				else
					next_words[off[4:1]][15:8] = rx_data;
			end
		end
		if (rx_end) begin // framer's idle gap closes the frame
			next_done = 1'b1;
			next_pos = 8'h00;
			next_crc_bad = rx_bad;
			next_bcast = rx_bcast;
			// byte count must be twice the register count
			if (multi)
				next_len_ok = ({1'b0, pos} == {1'b0, pmc_pkg::POS_DATA}
					+ {1'b0, nbytes}) && (count[15:8] == 8'h00)
					&& ({1'b0, nbytes} == {count[7:0], 1'b0});
			else
				next_len_ok = (pos == pmc_pkg::FIXED_LEN);
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			pos <= 8'h00;
			nbytes <= 8'h00;
			cmd <= 8'h00;
			addr <= 16'h0000;
			count <= 16'h0000;
			done <= 1'b0;
			len_ok <= 1'b0;
			crc_bad <= 1'b0;
			bcast <= 1'b0;
			words <= '{default: 16'h0000};
		end else begin
			pos <= next_pos;
			nbytes <= next_nbytes;
			cmd <= next_cmd;
			addr <= next_addr;
			count <= next_count;
			done <= next_done;
			len_ok <= next_len_ok;
			crc_bad <= next_crc_bad;
			bcast <= next_bcast;
			words <= next_words;
		end
	end

	assign p.done = done;
	assign p.cmd = cmd;
	assign p.addr = addr;
	assign p.count = count;
	assign p.len_ok = len_ok;
	assign p.crc_bad = crc_bad;
	assign p.bcast = bcast;
	assign p.words = words;
endmodule // pdu_collector

// file: logic/pdu_if.sv
// carrier for one decoded request between collector and command handler.
// fields stay stable from done until the next frame's first byte.
`timescale 1ns/1ns
interface pdu_if;
	logic          done;
	logic [7:0]    cmd;
	logic [15:0]   addr;
	logic [15:0]   count;
	logic          len_ok;
	logic          crc_bad;
	logic          bcast;
	pmc_pkg::word_t words [pmc_pkg::MAX_REGS];

	modport collector (output done, cmd, addr, count, len_ok, crc_bad, bcast,
		words);
	modport handler (input done, cmd, addr, count, len_ok, crc_bad, bcast,
		words);
endinterface // pdu_if

// file: logic/pmc_pkg.sv
// constants for the parameter command slave: command codes, exception
// codes, frame field positions and reply lengths.
// assumes a framer below it that strips address and checksum bytes.
package pmc_pkg;
	typedef logic [15:0] word_t;

	localparam logic [7:0] CMD_READ      = 8'h03;
	localparam logic [7:0] CMD_WRITE1    = 8'h06;
	localparam logic [7:0] CMD_WRITEN    = 8'h10;
	localparam logic [7:0] CMD_WRITE1_NV = 8'h41;
	localparam logic [7:0] CMD_WRITEN_NV = 8'h43;

	localparam logic [7:0] EXC_FLAG     = 8'h80;
	localparam logic [7:0] EXC_NONE     = 8'h00;
	localparam logic [7:0] EXC_CMD      = 8'h01;
	localparam logic [7:0] EXC_ADDR     = 8'h02;
	localparam logic [7:0] EXC_RANGE    = 8'h03;
	localparam logic [7:0] EXC_FAIL     = 8'h04;
	localparam logic [7:0] EXC_PENDING  = 8'h05;
	localparam logic [7:0] EXC_BUSY     = 8'h06;
	localparam logic [7:0] EXC_UNSUP    = 8'h16;
	localparam logic [7:0] EXC_COUNT    = 8'h17;
	localparam logic [7:0] EXC_FRAME    = 8'h18;
	localparam logic [7:0] EXC_RDONLY   = 8'h20;
	localparam logic [7:0] EXC_RUNLOCK  = 8'h21;
	localparam logic [7:0] EXC_PASSWORD = 8'h22;

	localparam int          MAX_REGS     = 10;
	localparam logic [15:0] MAX_COUNT    = 16'h000a;
	localparam logic [7:0]  POS_CMD      = 8'h00;
	localparam logic [7:0]  POS_ADDR_HI  = 8'h01;
	localparam logic [7:0]  POS_ADDR_LO  = 8'h02;
	localparam logic [7:0]  POS_CNT_HI   = 8'h03;
	localparam logic [7:0]  POS_CNT_LO   = 8'h04;
	localparam logic [7:0]  POS_NBYTES   = 8'h05;
	localparam logic [7:0]  POS_DATA     = 8'h06;
	localparam logic [7:0]  DATA_BYTES   = 8'h14;
	localparam logic [7:0]  FIXED_LEN    = 8'h05;
	localparam logic [4:0]  EXC_LEN      = 5'h02;
	localparam logic [4:0]  ECHO_LEN     = 5'h05;
	localparam logic [4:0]  READ_HDR_LEN = 5'h02;
endpackage

// file: verification/param_store_model.sv
// parameter store stand-in: checks, reads and commits parameter values.
// assumes the handler holds each request until it is acknowledged.
`timescale 1ns/1ns
module param_store_model (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        param_valid,
	input  wire logic [15:0] param_addr,
	input  wire logic [15:0] param_wdata,
	input  wire logic        param_write,
	input  wire logic        param_commit,
	input  wire logic        param_persist,
	output logic             param_ack,
	output logic [15:0]      param_rdata,
	output logic [7:0]       param_status
);
	int          lat;
	int          wait_n;
	logic [15:0] bad_addr;
	logic [7:0]  bad_code;
	logic        commit_bad;
	logic [32:0] log_q [$];

	initial begin
		lat = 0;
		wait_n = 0;
		bad_addr = 16'hffff;
		bad_code = 8'h00;
		commit_bad = 1'b0;
	end

	assign param_ack = param_valid && (wait_n >= lat);
	// released bus shows inverted data so a stale read cannot match
	assign param_rdata = param_valid ? param_addr + 16'h1000
		: ~(param_addr + 16'h1000);
	assign param_status = !param_valid ? 8'hee
		: (param_commit == commit_bad && param_addr == bad_addr) ? bad_code
		: 8'h00;

	always @(posedge clk) begin
		if (rst || param_ack || !param_valid)
			wait_n <= 0;
		else
			wait_n <= wait_n + 1;
		// a refused commit leaves the stored value alone
		if (!rst && param_ack && param_write && param_commit
			&& param_status == 8'h00)
			log_q.push_back({param_persist, param_addr, param_wdata});
	end
endmodule // param_store_model

// file: verification/testbench.sv
// self-checking bench for the parameter command handler.
// assumes the store model answers every parameter request.
`timescale 1ns/1ns
module testbench;
	typedef logic [7:0] byte_t;
	logic        clk;
	logic        rst;
	logic        rx_valid;
	logic [7:0]  rx_data;
	logic        rx_end;
	logic        rx_bad;
	logic        rx_bcast;
	logic        tx_valid;
	logic [7:0]  tx_data;
	logic        tx_last;
	logic        tx_ready;
	logic        param_valid;
	logic [15:0] param_addr;
	logic [15:0] param_wdata;
	logic        param_write;
	logic        param_commit;
	logic        param_persist;
	logic        param_ack;
	logic [15:0] param_rdata;
	logic [7:0]  param_status;
	logic        nonvolatile_save_select;
	logic        nv_save_busy;
	logic        busy;
	byte_t       req [$];
	byte_t       exp_r [$];
	logic [32:0] exp_c [$];
	int          err_total;
	int          n_compared;

	param_command_slave param_command_slave_inst (
		.clk(clk), .rst(rst), .rx_valid(rx_valid), .rx_data(rx_data),
		.rx_end(rx_end), .rx_bad(rx_bad), .rx_bcast(rx_bcast),
		.tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last),
		.tx_ready(tx_ready), .param_valid(param_valid),
		.param_addr(param_addr), .param_wdata(param_wdata),
		.param_write(param_write), .param_commit(param_commit),
		.param_persist(param_persist), .param_ack(param_ack),
		.param_rdata(param_rdata), .param_status(param_status),
		.nonvolatile_save_select(nonvolatile_save_select),
		.nv_save_busy(nv_save_busy), .busy(busy));

	param_store_model param_store_model_inst (
		.clk(clk), .rst(rst), .param_valid(param_valid),
		.param_addr(param_addr), .param_wdata(param_wdata),
		.param_write(param_write), .param_commit(param_commit),
		.param_persist(param_persist), .param_ack(param_ack),
		.param_rdata(param_rdata), .param_status(param_status));

	always #5 clk = ~clk;

	task automatic chk(input logic [32:0] got, input logic [32:0] exp);
		n_compared++;
		if (got !== exp) begin
			err_total++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// sends req, collects the reply with a stalling framer, judges both
	task automatic xfer(input logic bad, input logic bc);
		byte_t got [$];
		logic  last;
		param_store_model_inst.log_q.delete();
		foreach (req[k]) begin
			@(posedge clk);
			rx_valid <= 1'b1;
			rx_data  <= req[k];
		end
		@(posedge clk);
		rx_valid <= 1'b0;
		rx_data  <= ~req[req.size()-1];
		@(posedge clk);
		rx_end   <= 1'b1;
		rx_bad   <= bad;
		rx_bcast <= bc;
		@(posedge clk);
		rx_end   <= 1'b0;
		rx_bad   <= 1'b0;
		rx_bcast <= 1'b0;
		last = 1'b0;
		for (int i = 0; i < 300 && !last; i++) begin
			@(negedge clk);
			if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
				got.push_back(tx_data);
				last = tx_last;
				chk(33'(busy), 33'h1);
			end
			@(posedge clk);
			tx_ready <= (i % 3 != 1);
		end
		@(negedge clk);
		chk(33'(busy), 33'h0);
		chk(33'(got.size()), 33'(exp_r.size()));
		foreach (exp_r[k])
			chk(33'(got[k]), 33'(exp_r[k]));
		chk(33'(param_store_model_inst.log_q.size()), 33'(exp_c.size()));
		foreach (exp_c[k])
			chk(param_store_model_inst.log_q[k], exp_c[k]);
	endtask

	task automatic t_read();
		param_store_model_inst.lat = 2;
		req = '{pmc_pkg::CMD_READ, 8'h03, 8'h00, 8'h00, 8'h0a};
		exp_r = '{pmc_pkg::CMD_READ, 8'h14};
		exp_c = '{};
		for (int k = 0; k < 10; k++) begin
			exp_r.push_back(8'h13);
			exp_r.push_back(8'(k));
		end
		xfer(1'b0, 1'b0);
		$display("read test done");
	endtask

	task automatic t_w1(input byte_t cmd, input logic sel, input logic p);
		param_store_model_inst.lat = 0;
		nonvolatile_save_select <= sel;
		req = '{cmd, 8'h02, 8'h05, 8'hbe, 8'hef};
		exp_r = req;
		exp_c = '{{p, 16'h0205, 16'hbeef}};
		xfer(1'b0, 1'b0);
		$display("single write test done");
	endtask

	task automatic t_wn(input byte_t cmd, input logic sel, input logic p);
		param_store_model_inst.lat = 1;
		nonvolatile_save_select <= sel;
		req = '{cmd, 8'h0a, 8'h10, 8'h00, 8'h03, 8'h06,
			8'h11, 8'h11, 8'h22, 8'h22, 8'h33, 8'h33};
		exp_r = '{cmd, 8'h0a, 8'h10, 8'h00, 8'h03};
		exp_c = '{{p, 16'h0a10, 16'h1111}, {p, 16'h0a11, 16'h2222},
			{p, 16'h0a12, 16'h3333}};
		xfer(1'b0, 1'b0);
		$display("multiple write test done");
	endtask

	task automatic t_exc(input logic bad, input byte_t code);
		exp_r = '{req[0] + pmc_pkg::EXC_FLAG, code};
		exp_c = '{};
		xfer(bad, 1'b0);
		$display("exception test done");
	endtask

	task automatic t_store_codes();
		byte_t codes [7];
		codes = '{8'h03, 8'h04, 8'h05, 8'h16, 8'h20, 8'h21, 8'h22};
		param_store_model_inst.bad_addr = 16'h0a12;
		foreach (codes[k]) begin
			param_store_model_inst.bad_code = codes[k];
			req = '{pmc_pkg::CMD_WRITEN, 8'h0a, 8'h10, 8'h00, 8'h03, 8'h06,
				8'h11, 8'h11, 8'h22, 8'h22, 8'h33, 8'h33};
			t_exc(1'b0, codes[k]);
		end
		param_store_model_inst.commit_bad = 1'b1;
		param_store_model_inst.bad_code = pmc_pkg::EXC_RDONLY;
		exp_r = '{pmc_pkg::CMD_WRITEN + pmc_pkg::EXC_FLAG, pmc_pkg::EXC_FAIL};
		exp_c = '{{1'b0, 16'h0a10, 16'h1111}, {1'b0, 16'h0a11, 16'h2222}};
		xfer(1'b0, 1'b0);
		$display("commit failure test done");
		param_store_model_inst.commit_bad = 1'b0;
		param_store_model_inst.bad_code = pmc_pkg::EXC_ADDR;
		req = '{pmc_pkg::CMD_READ, 8'h0a, 8'h11, 8'h00, 8'h02};
		t_exc(1'b0, pmc_pkg::EXC_ADDR);
		param_store_model_inst.bad_addr = 16'hffff;
	endtask

	task automatic t_bcast();
		nonvolatile_save_select <= 1'b1;
		req = '{pmc_pkg::CMD_WRITE1, 8'h01, 8'h02, 8'h00, 8'h07};
		exp_r = '{};
		exp_c = '{{1'b1, 16'h0102, 16'h0007}};
		xfer(1'b0, 1'b1);
		req = '{pmc_pkg::CMD_READ, 8'h01, 8'h02, 8'h00, 8'h01};
		exp_c = '{};
		xfer(1'b0, 1'b1);
		$display("broadcast test done");
	endtask

	task automatic report_and_stop();
		$display("compared %0d mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	initial begin
		clk = 1'b0;
		rst = 1'b1;
		rx_valid = 1'b0;
		rx_data = 8'h00;
		rx_end = 1'b0;
		rx_bad = 1'b0;
		rx_bcast = 1'b0;
		tx_ready = 1'b1;
		nonvolatile_save_select = 1'b0;
		nv_save_busy = 1'b0;
		err_total = 0;
		n_compared = 0;
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		t_read();
		t_w1(pmc_pkg::CMD_WRITE1, 1'b0, 1'b0);
		t_w1(pmc_pkg::CMD_WRITE1, 1'b1, 1'b1);
		t_w1(pmc_pkg::CMD_WRITE1_NV, 1'b0, 1'b1);
		t_wn(pmc_pkg::CMD_WRITEN, 1'b1, 1'b1);
		t_wn(pmc_pkg::CMD_WRITEN_NV, 1'b0, 1'b1);
		req = '{8'h07, 8'h00, 8'h00, 8'h00, 8'h01};
		t_exc(1'b0, pmc_pkg::EXC_CMD);
		req = '{pmc_pkg::CMD_READ, 8'h00, 8'h00, 8'h00, 8'h01};
		t_exc(1'b1, pmc_pkg::EXC_FRAME);
		req = '{pmc_pkg::CMD_WRITE1, 8'h00, 8'h00, 8'h01};
		t_exc(1'b0, pmc_pkg::EXC_FRAME);
		req = '{pmc_pkg::CMD_READ, 8'h00, 8'h00, 8'h00, 8'h00};
		t_exc(1'b0, pmc_pkg::EXC_COUNT);
		req = '{pmc_pkg::CMD_READ, 8'h00, 8'h00, 8'h00, 8'h0b};
		t_exc(1'b0, pmc_pkg::EXC_COUNT);
		req = '{pmc_pkg::CMD_WRITEN, 8'hff, 8'hfe, 8'h00, 8'h03, 8'h06,
			8'h00, 8'h01, 8'h00, 8'h02, 8'h00, 8'h03};
		t_exc(1'b0, pmc_pkg::EXC_ADDR);
		nv_save_busy <= 1'b1;
		req = '{pmc_pkg::CMD_WRITE1, 8'h02, 8'h05, 8'h00, 8'h01};
		t_exc(1'b0, pmc_pkg::EXC_BUSY);
		nv_save_busy <= 1'b0;
		t_w1(pmc_pkg::CMD_WRITE1, 1'b0, 1'b0);
		t_store_codes();
		t_bcast();
		report_and_stop();
	end

	// about 25 transfers of at most 330 cycles each, with wide margin
	initial begin
		#300000;
		err_total++;
		report_and_stop();
	end
endmodule // testbench
